// ### core/isr_status_top.sv
`timescale 1ns/10ps
module isr_status_top
  import isr_pkg::*;
(
  // Clock and reset.
  input  wire logic          i_clk,
  input  wire logic          i_rstn,
  // Command port from the remote-command parser.
  input  wire isr_cmd_t      i_cmd,
  output isr_rsp_t           o_rsp,
  // Queue levels and outside summaries.
  input  wire logic          i_error_queue_nonempty,
  input  wire logic          i_output_queue_nonempty,
  input  wire logic          i_std_event_summary,
  input  wire logic          i_oper_event_summary,
  input  wire logic          i_meas_integrity_event,
  input  wire logic          i_limit_summary,
  input  wire logic          i_define_summary,
  // Hardware fault conditions.
  input  wire isr_hw_fault_t i_hw_fault,
  // Non-volatile store of the service-request mask.
  input  wire logic [7:0]    i_nv_sre,
  output logic               o_nv_sre_wr,
  output logic      [7:0]    o_nv_sre_data,
  // Results.
  output logic               o_error_queue_clear,
  output logic      [7:0]    o_stb,
  output logic               o_srq
);

  logic        sre_loaded;
  logic [7:0]  service_request_mask;
  logic [7:0]  stb_live;
  logic        rqs;
  logic [15:0] hw_cond;
  logic [15:0] int_cond;
  logic [15:0] ques_cond;
  logic [15:0] hw_c, hw_e, hw_en, hw_r, hw_f;
  logic [15:0] int_c, int_e, int_en, int_r, int_f;
  logic [15:0] q_c, q_e, q_en, q_r, q_f;
  logic        hw_sum, int_sum, ques_sum;
  logic        clear;
  logic [2:0]  sel;
  logic [2:0]  rd_ev, wr_en, wr_ri, wr_fa;
  logic [15:0] next_rsp_data;

  function automatic logic [15:0] pick(input isr_tgt_t t, input logic [15:0] q, input logic [15:0] i,
                                       input logic [15:0] h);
    unique case (t)
      ISR_TGT_QUES: pick = q;
      ISR_TGT_INT:  pick = i;
      ISR_TGT_HW:   pick = h;
      default:      pick = 16'h0000;
    endcase
  endfunction : pick

  always_comb begin
    hw_cond = 16'h0000;
    hw_cond[HW_PHASE_UNLOCK_BIT] = i_hw_fault.phase_unlock;
    hw_cond[HW_UNLEVELED_BIT]    = i_hw_fault.source_unleveled;
    hw_cond[HW_OVERPOWER_BIT]    = i_hw_fault.input_overpower;
    hw_cond[HW_NVSTORE_BIT]      = i_hw_fault.nvstore_write_fail;
    hw_cond[HW_OSC_CAL_BIT]      = i_hw_fault.oscillator_cal_fail;
    hw_cond[HW_RAMP_CAL_BIT]     = i_hw_fault.ramp_cal_fail;
    hw_cond[HW_SOURCE_OVER_TEMPERATURE_BIT]     = i_hw_fault.source_over_temperature;
  end

  always_comb begin
    int_cond = 16'h0000;
    int_cond[INT_MEAS_BIT] = i_meas_integrity_event;
    int_cond[INT_HW_BIT]   = |hw_e;
    ques_cond = 16'h0000;
    ques_cond[QUES_INT_BIT] = int_sum;
    ques_cond[QUES_LIM_BIT] = i_limit_summary;
    ques_cond[QUES_DEF_BIT] = i_define_summary;
  end

  // Per-register command strobes, index 0 questionable, 1 integrity, 2 hardware.
  assign clear = i_cmd.valid && (i_cmd.op == ISR_CLEAR_STATUS);
  assign sel   = {i_cmd.tgt == ISR_TGT_HW, i_cmd.tgt == ISR_TGT_INT, i_cmd.tgt == ISR_TGT_QUES};
  assign rd_ev = (i_cmd.valid && i_cmd.op == ISR_READ_EVENT) ? sel : 3'b000;
  assign wr_en = (i_cmd.valid && i_cmd.op == ISR_WRITE_ENABLE) ? sel : 3'b000;
  assign wr_ri = (i_cmd.valid && i_cmd.op == ISR_WRITE_RISE) ? sel : 3'b000;
  assign wr_fa = (i_cmd.valid && i_cmd.op == ISR_WRITE_FALL) ? sel : 3'b000;

  isr_stat_reg #(
    .VALID_MASK (HW_VALID_MASK)
  ) u_hw (
    .i_clk       (i_clk),
    .i_rstn      (i_rstn),
    .i_cond      (hw_cond),
    .i_wr_enable (wr_en[2]),
    .i_wr_rise   (wr_ri[2]),
    .i_wr_fall   (wr_fa[2]),
    .i_wdata     (i_cmd.data),
    .i_rd_event  (rd_ev[2]),
    .i_clear     (clear),
    .o_cond      (hw_c),
    .o_event     (hw_e),
    .o_enable    (hw_en),
    .o_rise      (hw_r),
    .o_fall      (hw_f),
    .o_summary   (hw_sum)
  );

  isr_stat_reg #(
    .VALID_MASK (INT_VALID_MASK)
  ) u_int (
    .i_clk       (i_clk),
    .i_rstn      (i_rstn),
    .i_cond      (int_cond),
    .i_wr_enable (wr_en[1]),
    .i_wr_rise   (wr_ri[1]),
    .i_wr_fall   (wr_fa[1]),
    .i_wdata     (i_cmd.data),
    .i_rd_event  (rd_ev[1]),
    .i_clear     (clear),
    .o_cond      (int_c),
    .o_event     (int_e),
    .o_enable    (int_en),
    .o_rise      (int_r),
    .o_fall      (int_f),
    .o_summary   (int_sum)
  );

  isr_stat_reg #(
    .VALID_MASK (QUES_VALID_MASK)
  ) u_ques (
    .i_clk       (i_clk),
    .i_rstn      (i_rstn),
    .i_cond      (ques_cond),
    .i_wr_enable (wr_en[0]),
    .i_wr_rise   (wr_ri[0]),
    .i_wr_fall   (wr_fa[0]),
    .i_wdata     (i_cmd.data),
    .i_rd_event  (rd_ev[0]),
    .i_clear     (clear),
    .o_cond      (q_c),
    .o_event     (q_e),
    .o_enable    (q_en),
    .o_rise      (q_r),
    .o_fall      (q_f),
    .o_summary   (ques_sum)
  );

  // The summary byte is a live view; its request bit ignores the mask bit 6.
  always_comb begin
    stb_live = 8'h00;
    stb_live[STB_EAV_BIT]  = i_error_queue_nonempty;
    stb_live[STB_QUES_BIT] = ques_sum;
    stb_live[STB_MAV_BIT]  = i_output_queue_nonempty;
    stb_live[STB_STD_BIT]  = i_std_event_summary;
    stb_live[STB_OPER_BIT] = i_oper_event_summary;
    rqs = |(stb_live & service_request_mask & SRE_VALID_MASK);
    stb_live[STB_RQS_BIT]  = rqs;
    stb_live = stb_live & STB_VALID_MASK;
  end

  // The mask is restored from the non-volatile store once after reset.
  always_ff @(posedge i_clk) begin
    if (!i_rstn) begin
      service_request_mask        <= SRE_RESET;
      sre_loaded <= 1'b0;
    end else if (i_cmd.valid && i_cmd.op == ISR_WRITE_SRE) begin
      service_request_mask        <= i_cmd.data[7:0] & SRE_VALID_MASK;
      sre_loaded <= 1'b1;
    end else if (!sre_loaded) begin
      service_request_mask        <= i_nv_sre & SRE_VALID_MASK;
      sre_loaded <= 1'b1;
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_rstn) begin
      o_nv_sre_wr   <= 1'b0;
      o_nv_sre_data <= 8'h00;
    end else begin
      o_nv_sre_wr <= i_cmd.valid && (i_cmd.op == ISR_WRITE_SRE);
      if (i_cmd.valid && i_cmd.op == ISR_WRITE_SRE) begin
        o_nv_sre_data <= i_cmd.data[7:0] & SRE_VALID_MASK;
      end
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_rstn) begin
      o_error_queue_clear <= 1'b0;
    end else begin
      o_error_queue_clear <= clear;
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_rstn) begin
      o_stb <= 8'h00;
      o_srq <= 1'b0;
    end else begin
      o_stb <= stb_live;
      o_srq <= rqs;
    end
  end

  always_comb begin
    unique case (i_cmd.op)
      ISR_READ_STB:    next_rsp_data = {8'h00, stb_live};
      ISR_READ_SRE:    next_rsp_data = {8'h00, service_request_mask};
      ISR_READ_COND:   next_rsp_data = pick(i_cmd.tgt, q_c, int_c, hw_c);
      ISR_READ_EVENT:  next_rsp_data = pick(i_cmd.tgt, q_e, int_e, hw_e);
      ISR_READ_ENABLE: next_rsp_data = pick(i_cmd.tgt, q_en, int_en, hw_en);
      ISR_READ_RISE:   next_rsp_data = pick(i_cmd.tgt, q_r, int_r, hw_r);
      ISR_READ_FALL:   next_rsp_data = pick(i_cmd.tgt, q_f, int_f, hw_f);
      default:         next_rsp_data = 16'h0000;
    endcase
  end

  // Every command is answered one cycle later; writes answer with zero.
  always_ff @(posedge i_clk) begin
    if (!i_rstn) begin
      o_rsp <= '0;
    end else begin
      o_rsp.valid <= i_cmd.valid;
      o_rsp.data  <= i_cmd.valid ? next_rsp_data : 16'h0000;
    end
  end

endmodule : isr_status_top

// ### core/isr_pkg.sv
// How it works
// - Clear-status empties every event register and the error queue; enable masks stay unchanged.
// - Reading the summary status byte returns it unchanged.
// - Service-request mask is kept in non-volatile store; writing zero disables every source.
// - Summary bit 2 is one while the error queue is not empty.
// - Summary bit 3 is one when any enabled questionable event bit is one.
// - Summary bit 4 is one while the output queue is not empty.
// - Summary bit 6 requests service from any enabled other bit; it cannot be masked.
// - Undefined bits of every status register read zero.
// - Questionable bit 9 is one when any enabled integrity event bit is one.
// - Questionable bit 10 summarises limit events, bit 11 user-define events.
// - Integrity bit 0 is one when any measurement-integrity event bit is one.
// - Integrity bit 1 is one when any hardware-fault event bit is one.
// - Hardware-fault bit 1 rises on source phase-lock loss.
// - Hardware-fault bit 2 rises on unleveled source power.
// - Hardware-fault bit 3 rises on excessive input power.
// - Hardware-fault bit 4 rises on a failed non-volatile store write.
// - Hardware-fault bit 5 rises on failed oscillator calibration.
// - Hardware-fault bit 6 rises on failed sweep ramp calibration.
// - Hardware-fault bit 7 rises on source over-temperature.
package isr_pkg;

  // Summary status byte bit positions.
  localparam int STB_EAV_BIT  = 2;
  localparam int STB_QUES_BIT = 3;
  localparam int STB_MAV_BIT  = 4;
  localparam int STB_STD_BIT  = 5;
  localparam int STB_RQS_BIT  = 6;
  localparam int STB_OPER_BIT = 7;
  localparam logic [7:0] STB_VALID_MASK = 8'hFC;
  localparam logic [7:0] SRE_VALID_MASK = 8'hBC;
  localparam logic [7:0] SRE_RESET      = 8'h00;

  // Questionable data summary bit positions.
  localparam int QUES_INT_BIT = 9;
  localparam int QUES_LIM_BIT = 10;
  localparam int QUES_DEF_BIT = 11;
  localparam logic [15:0] QUES_VALID_MASK = 16'h0E00;

  // Integrity summary bit positions.
  localparam int INT_MEAS_BIT = 0;
  localparam int INT_HW_BIT   = 1;
  localparam logic [15:0] INT_VALID_MASK = 16'h0003;

  // Hardware fault status bits 1 to 7 are defined.
  localparam int HW_PHASE_UNLOCK_BIT = 1;
  localparam int HW_UNLEVELED_BIT    = 2;
  localparam int HW_OVERPOWER_BIT    = 3;
  localparam int HW_NVSTORE_BIT      = 4;
  localparam int HW_OSC_CAL_BIT      = 5;
  localparam int HW_RAMP_CAL_BIT     = 6;
  localparam int HW_SOURCE_OVER_TEMPERATURE_BIT     = 7;
  localparam logic [15:0] HW_VALID_MASK = 16'h00FE;

  // Values after reset of the per-register views.
  localparam logic [15:0] ENABLE_RESET = 16'h0000;
  localparam logic [15:0] RISE_RESET   = 16'hFFFF;
  localparam logic [15:0] FALL_RESET   = 16'h0000;

  typedef enum logic [3:0] {
    ISR_CLEAR_STATUS,
    ISR_READ_STB,
    ISR_WRITE_SRE,
    ISR_READ_SRE,
    ISR_READ_COND,
    ISR_READ_EVENT,
    ISR_READ_ENABLE,
    ISR_WRITE_ENABLE,
    ISR_READ_RISE,
    ISR_WRITE_RISE,
    ISR_READ_FALL,
    ISR_WRITE_FALL
  } isr_op_t;

  typedef enum logic [1:0] {
    ISR_TGT_QUES,
    ISR_TGT_INT,
    ISR_TGT_HW
  } isr_tgt_t;

  typedef struct packed {
    logic        valid;
    isr_op_t     op;
    isr_tgt_t    tgt;
    logic [15:0] data;
  } isr_cmd_t;

  typedef struct packed {
    logic        valid;
    logic [15:0] data;
  } isr_rsp_t;

  typedef struct packed {
    logic source_over_temperature;
    logic ramp_cal_fail;
    logic oscillator_cal_fail;
    logic nvstore_write_fail;
    logic input_overpower;
    logic source_unleveled;
    logic phase_unlock;
  } isr_hw_fault_t;

endpackage : isr_pkg

// ### core/isr_stat_reg.sv
`timescale 1ns/10ps
module isr_stat_reg
  import isr_pkg::*;
#(
  parameter logic [15:0] VALID_MASK = 16'hFFFF
) (
  // Clock and reset.
  input  wire logic        i_clk,
  input  wire logic        i_rstn,
  // Live condition inputs.
  input  wire logic [15:0] i_cond,
  // Register writes, event read and clear-status.
  input  wire logic        i_wr_enable,
  input  wire logic        i_wr_rise,
  input  wire logic        i_wr_fall,
  input  wire logic [15:0] i_wdata,
  input  wire logic        i_rd_event,
  input  wire logic        i_clear,
  // Views and summary.
  output logic      [15:0] o_cond,
  output logic      [15:0] o_event,
  output logic      [15:0] o_enable,
  output logic      [15:0] o_rise,
  output logic      [15:0] o_fall,
  output logic             o_summary
);

  logic [15:0] prev_cond;
  logic [15:0] set_bits;

  assign o_cond = i_cond & VALID_MASK;

  // A rising or falling condition edge passed by its filter latches the event.
  assign set_bits = ((o_cond & ~prev_cond & o_rise) | (~o_cond & prev_cond & o_fall)) & VALID_MASK;

  assign o_summary = |(o_event & o_enable);

  always_ff @(posedge i_clk) begin
    if (!i_rstn) begin
      prev_cond <= 16'h0000;
    end else begin
      prev_cond <= o_cond;
    end
  end

  // A new edge in the cycle of a read or clear still sets its bit.
  always_ff @(posedge i_clk) begin
    if (!i_rstn) begin
      o_event <= 16'h0000;
    end else if (i_clear || i_rd_event) begin
      o_event <= set_bits;
    end else begin
      o_event <= o_event | set_bits;
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_rstn) begin
      o_enable <= ENABLE_RESET;
      o_rise   <= RISE_RESET & VALID_MASK;
      o_fall   <= FALL_RESET;
    end else begin
      if (i_wr_enable) begin
        o_enable <= i_wdata & VALID_MASK;
      end
      if (i_wr_rise) begin
        o_rise <= i_wdata & VALID_MASK;
      end
      if (i_wr_fall) begin
        o_fall <= i_wdata & VALID_MASK;
      end
    end
  end

endmodule : isr_stat_reg

// ### test/isr_status_sva.sv
`timescale 1ns/10ps
module isr_status_sva
  import isr_pkg::*;
(
  // Clock, reset and commands.
  input wire logic          i_clk,
  input wire logic          i_rstn,
  input wire isr_cmd_t      i_cmd,
  input wire isr_rsp_t      o_rsp,
  // Levels.
  input wire logic          i_error_queue_nonempty,
  input wire logic          i_output_queue_nonempty,
  input wire logic          i_std_event_summary,
  input wire logic          i_oper_event_summary,
  // Results.
  input wire logic          o_nv_sre_wr,
  input wire logic [7:0]    o_nv_sre_data,
  input wire logic          o_error_queue_clear,
  input wire logic [7:0]    o_stb,
  input wire logic          o_srq
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_rstn);
  sequence s_cmd(isr_op_t op);
    i_cmd.valid && i_cmd.op == op;
  endsequence
  property p_eav; $past(i_rstn) |-> o_stb[STB_EAV_BIT] == $past(i_error_queue_nonempty); endproperty
  property p_mav; $past(i_rstn) |-> o_stb[STB_MAV_BIT] == $past(i_output_queue_nonempty); endproperty
  property p_std; $past(i_rstn) |-> o_stb[STB_STD_BIT] == $past(i_std_event_summary); endproperty
  property p_opr; $past(i_rstn) |-> o_stb[STB_OPER_BIT] == $past(i_oper_event_summary); endproperty
  property p_rqs; o_stb[STB_RQS_BIT] |-> (o_stb & SRE_VALID_MASK) != 8'h00; endproperty
  property p_srq; o_srq == o_stb[STB_RQS_BIT]; endproperty
  property p_unused; o_stb[1:0] == 2'b00; endproperty
  property p_cls; s_cmd(ISR_CLEAR_STATUS) |=> o_error_queue_clear; endproperty
  property p_nvwr;
    s_cmd(ISR_WRITE_SRE) |=> o_nv_sre_wr && o_nv_sre_data == ($past(i_cmd.data[7:0]) & SRE_VALID_MASK);
  endproperty
  property p_stbrd; s_cmd(ISR_READ_STB) |=> o_rsp.valid && o_rsp.data == {8'h00, o_stb}; endproperty
  a_eav: assert property (p_eav) else $error("queue summary bit wrong");
  a_mav: assert property (p_mav) else $error("message bit wrong");
  a_std: assert property (p_std) else $error("standard summary bit wrong");
  a_opr: assert property (p_opr) else $error("operation summary bit wrong");
  a_rqs: assert property (p_rqs) else $error("service request without source");
  a_srq: assert property (p_srq) else $error("request line differs from byte");
  a_unused: assert property (p_unused) else $error("unused bits set");
  a_cls: assert property (p_cls) else $error("queue clear missing");
  a_nvwr: assert property (p_nvwr) else $error("mask store write wrong");
  a_stbrd: assert property (p_stbrd) else $error("byte read differs");
endmodule : isr_status_sva

bind isr_status_top isr_status_sva u_isr_status_sva (
  .i_clk(i_clk), .i_rstn(i_rstn), .i_cmd(i_cmd), .o_rsp(o_rsp),
  .i_error_queue_nonempty(i_error_queue_nonempty), .i_output_queue_nonempty(i_output_queue_nonempty),
  .i_std_event_summary(i_std_event_summary), .i_oper_event_summary(i_oper_event_summary),
  .o_nv_sre_wr(o_nv_sre_wr), .o_nv_sre_data(o_nv_sre_data), .o_error_queue_clear(o_error_queue_clear),
  .o_stb(o_stb), .o_srq(o_srq)
);

// ### test/isr_nv_model.sv
`timescale 1ns/10ps
module isr_nv_model #(
  parameter logic [7:0] INIT = 8'h24
) (
  input  wire logic       i_clk,
  input  wire logic       i_wr,
  input  wire logic [7:0] i_data,
  output logic      [7:0] o_sre
);
  // The store has no reset: its content survives the block's reset.
  initial o_sre = INIT;
  always @(posedge i_clk) begin
    if (i_wr) begin
      o_sre <= i_data;
    end
  end
endmodule : isr_nv_model

// ### test/tb_top.sv
`timescale 1ns/10ps
module tb_top
  import isr_pkg::*;
;
  logic          i_clk, i_rstn, eq, oq, std, opr, meas, lim, def, nv_wr, eq_clr, srq;
  logic [7:0]    nv_sre, nv_data, stb, r;
  isr_cmd_t      cmd_r;
  isr_rsp_t      rsp;
  isr_hw_fault_t hw;
  logic [15:0]   exp_q[$];
  int            n_mismatch, comparisons, cycles;

  isr_status_top u_isr_status_top (.i_clk(i_clk), .i_rstn(i_rstn), .i_cmd(cmd_r), .o_rsp(rsp),
    .i_error_queue_nonempty(eq), .i_output_queue_nonempty(oq), .i_std_event_summary(std),
    .i_oper_event_summary(opr), .i_meas_integrity_event(meas), .i_limit_summary(lim),
    .i_define_summary(def), .i_hw_fault(hw), .i_nv_sre(nv_sre), .o_nv_sre_wr(nv_wr),
    .o_nv_sre_data(nv_data), .o_error_queue_clear(eq_clr), .o_stb(stb), .o_srq(srq));
  isr_nv_model u_isr_nv_model (.i_clk(i_clk), .i_wr(nv_wr), .i_data(nv_data), .o_sre(nv_sre));

  initial begin
    i_clk = 1'b0;
    forever #4 i_clk = ~i_clk;
  end

  task automatic chk(input logic [15:0] seen, input logic [15:0] e);
    comparisons++;
    if (seen !== e) begin
      n_mismatch++;
      $display("FAIL %0t: got %h expected %h", $time, seen, e);
    end
  endtask : chk

  task automatic print_verdict();
    $display("mismatches %0d comparisons %0d", n_mismatch, comparisons);
    if (n_mismatch == 0 && comparisons > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : print_verdict

  task automatic cmd(input isr_op_t op, input isr_tgt_t tg, input logic [15:0] d, input logic [15:0] e);
    @(posedge i_clk);
    cmd_r <= '{1'b1, op, tg, d};
    exp_q.push_back(e);
    @(posedge i_clk);
    cmd_r.valid <= 1'b0;
  endtask : cmd

  task automatic w(input int n);
    repeat (n) @(posedge i_clk);
  endtask : w

  // Responses are sampled mid-cycle and matched against the oldest note.
  always @(negedge i_clk) begin
    if (rsp.valid === 1'b1) begin
      if (exp_q.size() == 0) chk(rsp.data, 16'hdead);
      else chk(rsp.data, exp_q.pop_front());
    end
  end

  always @(posedge i_clk) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      n_mismatch++;
      print_verdict();
    end
  end

  initial begin
    {i_rstn, eq, oq, std, opr, meas, lim, def} = '0;
    cmd_r = '0;
    hw = '0;
    cycles = 0;
    void'($urandom(80));
    w(12);
    i_rstn <= 1'b1;
    w(2);
    cmd(ISR_READ_SRE, ISR_TGT_QUES, 16'h0000, 16'h0024);
    r = 8'($urandom());
    cmd(ISR_WRITE_SRE, ISR_TGT_QUES, {8'h00, r}, 16'h0000);
    cmd(ISR_READ_SRE, ISR_TGT_QUES, 16'h0000, {8'h00, r & SRE_VALID_MASK});
    cmd(ISR_WRITE_SRE, ISR_TGT_QUES, 16'h0004, 16'h0000);
    eq <= 1'b1;
    w(3);
    cmd(ISR_READ_STB, ISR_TGT_QUES, 16'h0000, 16'h0044);
    oq <= 1'b1;
    w(3);
    cmd(ISR_READ_STB, ISR_TGT_QUES, 16'h0000, 16'h0054);
    cmd(ISR_WRITE_SRE, ISR_TGT_QUES, 16'h0000, 16'h0000);
    w(3);
    cmd(ISR_READ_STB, ISR_TGT_QUES, 16'h0000, 16'h0014);
    std <= 1'b1;
    opr <= 1'b1;
    cmd(ISR_WRITE_SRE, ISR_TGT_QUES, 16'h0080, 16'h0000);
    w(3);
    cmd(ISR_READ_STB, ISR_TGT_QUES, 16'h0000, 16'h00f4);
    {eq, oq, std, opr} <= '0;
    cmd(ISR_WRITE_ENABLE, ISR_TGT_HW, 16'h00fe, 16'h0000);
    cmd(ISR_WRITE_ENABLE, ISR_TGT_INT, 16'h0003, 16'h0000);
    cmd(ISR_WRITE_ENABLE, ISR_TGT_QUES, 16'h0e00, 16'h0000);
    cmd(ISR_WRITE_SRE, ISR_TGT_QUES, 16'h0008, 16'h0000);
    for (int i = 1; i < 8; i++) begin
      hw <= isr_hw_fault_t'(7'h01 << (i - 1));
      w(5);
      cmd(ISR_READ_STB, ISR_TGT_QUES, 16'h0000, 16'h0048);
      cmd(ISR_READ_COND, ISR_TGT_HW, 16'h0000, 16'h0001 << i);
      cmd(ISR_READ_EVENT, ISR_TGT_HW, 16'h0000, 16'h0001 << i);
      cmd(ISR_READ_EVENT, ISR_TGT_HW, 16'h0000, 16'h0000);
      hw <= '0;
      w(2);
    end
    cmd(ISR_READ_EVENT, ISR_TGT_INT, 16'h0000, 16'h0002);
    cmd(ISR_READ_EVENT, ISR_TGT_QUES, 16'h0000, 16'h0200);
    w(2);
    cmd(ISR_READ_STB, ISR_TGT_QUES, 16'h0000, 16'h0000);
    {meas, lim, def} <= 3'b111;
    w(5);
    cmd(ISR_READ_COND, ISR_TGT_INT, 16'h0000, 16'h0001);
    cmd(ISR_READ_COND, ISR_TGT_QUES, 16'h0000, 16'h0e00);
    cmd(ISR_CLEAR_STATUS, ISR_TGT_QUES, 16'h0000, 16'h0000);
    cmd(ISR_READ_EVENT, ISR_TGT_INT, 16'h0000, 16'h0000);
    cmd(ISR_READ_EVENT, ISR_TGT_QUES, 16'h0000, 16'h0000);
    cmd(ISR_READ_ENABLE, ISR_TGT_QUES, 16'h0000, 16'h0e00);
    cmd(ISR_READ_SRE, ISR_TGT_QUES, 16'h0000, 16'h0008);
    {meas, lim, def} <= '0;
    cmd(ISR_WRITE_ENABLE, ISR_TGT_HW, 16'hffff, 16'h0000);
    cmd(ISR_READ_ENABLE, ISR_TGT_HW, 16'h0000, 16'h00fe);
    cmd(ISR_READ_ENABLE, isr_tgt_t'(2'h3), 16'h0000, 16'h0000);
    cmd(ISR_READ_RISE, ISR_TGT_HW, 16'h0000, 16'h00fe);
    cmd(ISR_WRITE_RISE, ISR_TGT_HW, 16'h0000, 16'h0000);
    cmd(ISR_WRITE_FALL, ISR_TGT_HW, 16'h0002, 16'h0000);
    cmd(ISR_READ_FALL, ISR_TGT_HW, 16'h0000, 16'h0002);
    hw <= isr_hw_fault_t'(7'h01);
    w(4);
    cmd(ISR_READ_EVENT, ISR_TGT_HW, 16'h0000, 16'h0000);
    hw <= '0;
    w(4);
    cmd(ISR_READ_EVENT, ISR_TGT_HW, 16'h0000, 16'h0002);
    w(4);
    chk(16'(exp_q.size()), 16'h0000);
    print_verdict();
  end
endmodule : tb_top
